// [core/gcs_regs.svh]
// Purpose: register map constants for the pin and scan control bank
// Assumes: Avalon-MM byte addresses, one aligned word per register
// Notes: printed offsets are register indices; byte address is four times index
`ifndef GCS_REGS_SVH
`define GCS_REGS_SVH
// ****************************************
// register indices
// ****************************************
`define GCS_IDX_PIN_CFG 6'h05
`define GCS_IDX_DIR_CFG 6'h07
`define GCS_IDX_DRIVE 6'h09
`define GCS_IDX_OUT_LVL 6'h0B
`define GCS_IDX_IN_LVL 6'h0D
`define GCS_IDX_SCAN_CTL 6'h10
`define GCS_IDX_MAN_SEL 6'h11
`define GCS_IDX_AUTO_EN 6'h12
// ****************************************
// field positions and values
// ****************************************
`define GCS_START_BIT 4
`define GCS_MODE_LSB 0
`define GCS_MODE_MSB 1
`define GCS_CHID_MSB 3
`define GCS_RST8 8'h00
`define GCS_SCAN_CTL_MASK 8'h13
`define GCS_MAN_SEL_MASK 8'h0F
`define GCS_UNMAPPED_DATA 32'h0000_0000
`endif

// [core/gcs_pkg.sv]
// Purpose: shared types of the pin and scan control bank
// Assumes: eight channels
// Notes: scan mode codes are fixed by the register encoding
package gcs_pkg;
  // ****************************************
  // scan mode encoding
  // ****************************************
  typedef enum logic [1:0] {
    GCS_MODE_MANUAL = 2'h0,
    GCS_MODE_AUTO = 2'h1,
    GCS_MODE_FLY = 2'h2,
    GCS_MODE_RSVD = 2'h3
  } gcs_mode_type;
endpackage : gcs_pkg

// [core/gcs_pin_if.sv]
// Purpose: carries per-channel pin configuration between bank and pad logic
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ps
interface gcs_pin_if #(parameter int N = 8);
  logic [N-1:0] is_digital; // 1 = general purpose pin
  logic [N-1:0] is_output; // 1 = output direction
  logic [N-1:0] push_pull; // 1 = push-pull, 0 = open drain
  logic [N-1:0] level; // level to drive
  modport bank (output is_digital, output is_output, output push_pull, output level);
  modport pad (input is_digital, input is_output, input push_pull, input level);
endinterface : gcs_pin_if

// [core/gcs_pad_ctl.sv]
// Purpose: turns pin configuration into pad drive and input sampling
// Assumes: pad inputs are asynchronous to clock
// Notes: open drain drives low only, floats for high
`timescale 1ns/1ps
module gcs_pad_ctl #(
  parameter int N = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // configuration
  gcs_pin_if.pad cfg,
  // pads
  input wire logic [N-1:0] pad_in,
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe,
  // sampled levels
  output logic [N-1:0] in_level
);
  logic [N-1:0] sync1_r; // first stage, read only by second
  logic [N-1:0] sync2_r; // second stage
  logic [N-1:0] out_r; // registered pad data
  logic [N-1:0] oe_r; // registered pad enable
  // ****************************************
  // input synchroniser
  // ****************************************
  // two stages since pads are outside the clock domain
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
    end
  end
  assign in_level = sync2_r; // [RULE3]
  // ****************************************
  // output drive
  // ****************************************
  // driver enabled only for digital pins in output direction
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_r <= '0;
      oe_r <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        out_r[i] <= cfg.level[i]; // [RULE2]
        if (cfg.is_digital[i] && cfg.is_output[i]) begin // [RULE13] [RULE10] [RULE11]
          // open drain only pulls low
          oe_r[i] <= cfg.push_pull[i] | ~cfg.level[i]; // [RULE1]
        end else begin
          oe_r[i] <= 1'b0;
        end
      end
    end
  end
  assign pad_out = out_r;
  assign pad_oe = oe_r;
endmodule : gcs_pad_ctl

// [core/gcs_scan_ctl.sv]
// Purpose: picks the channel the converter core works on
// Assumes: core pulses conv_done after each conversion
// Notes: auto scan skips disabled channels, ascending with wrap
`timescale 1ns/1ps
`include "gcs_regs.svh"
module gcs_scan_ctl #(
  parameter int N = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // configuration
  input wire gcs_pkg::gcs_mode_type mode,
  input wire logic start,
  input wire logic [3:0] manual_id,
  input wire logic [N-1:0] enables,
  input wire logic [N-1:0] is_digital,
  // core side
  input wire logic conv_done,
  output logic scan_active,
  output logic [2:0] chan,
  output logic chan_valid
);
  typedef enum logic [1:0] {GCS_IDLE, GCS_RUN} gcs_state_type;
  gcs_state_type state_r; // scan state
  logic [2:0] auto_r; // current auto channel
  logic [2:0] next_ch; // next enabled channel
  logic run_ok; // auto mode with start set and at least one enable bit set
  // next enabled analog channel above cur, wrapping
  function automatic logic [2:0] gcs_next(input logic [2:0] cur, input logic [N-1:0] en);
    logic [2:0] res;
    logic [2:0] c;
    res = cur;
    for (int k = N; k >= 1; k--) begin
      c = 3'((int'(cur) + k) % N);
      if (en[c]) begin
        res = c;
      end
    end
    return res;
  endfunction : gcs_next
  assign run_ok = (mode == gcs_pkg::GCS_MODE_AUTO) && start && (enables != '0); // [RULE6] [RULE5]
  assign next_ch = gcs_next(auto_r, enables & ~is_digital); // [RULE12]
  // ****************************************
  // sequence state
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= GCS_IDLE;
      auto_r <= 3'h7;
    end else begin
      unique case (state_r)
        GCS_IDLE: begin
          auto_r <= 3'h7; // so first pick is lowest channel
          if (run_ok) begin
            state_r <= GCS_RUN; // [RULE5]
            auto_r <= gcs_next(3'h7, enables & ~is_digital);
          end
        end
        GCS_RUN: begin
          if (!run_ok) begin
            state_r <= GCS_IDLE; // clearing start stops the scan
          end else if (conv_done) begin
            auto_r <= next_ch; // ascending order
          end
        end
        default: state_r <= GCS_IDLE;
      endcase
    end
  end
  // ****************************************
  // channel output
  // ****************************************
  // top bit of manual id is reserved; treated as no channel
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      chan <= 3'h0;
      chan_valid <= 1'b0;
    end else if (mode == gcs_pkg::GCS_MODE_MANUAL) begin // [RULE7]
      chan <= manual_id[2:0]; // [RULE8]
      chan_valid <= ~manual_id[`GCS_CHID_MSB]; // [RULE8]
    end else if (state_r == GCS_RUN) begin
      chan <= auto_r;
      chan_valid <= (enables & ~is_digital) != '0;
    end else begin
      chan_valid <= 1'b0; // on-the-fly and reserved select nothing here
    end
  end
  assign scan_active = (state_r == GCS_RUN);
endmodule : gcs_scan_ctl

// [core/gcs_bank.sv]
// Purpose: register bank for pin configuration and channel scan control
// Assumes: Avalon-MM slave, 32-bit data, word aligned byte addresses
// Notes: every access answers in the cycle after it is seen
// What this block does
// [RULE1] drive bit: 0 open drain, 1 push-pull
// [RULE2] output level bit sets driven logic level
// [RULE3] input level register reads sampled pin levels
// [RULE4] reserved control bits read as zero
// [RULE5] start bit runs ascending scan, clear stops
// [RULE6] start acts only in automatic mode
// [RULE7] mode field: manual, auto, on-the-fly, reserved
// [RULE8] manual id picks input; top bit reserved
// [RULE9] host picks only analog channels manually
// [RULE10] pin config bit: 0 analog, 1 digital
// [RULE11] direction bit: 0 input, 1 output
// [RULE12] enable bit includes channel in auto scan
// [RULE13] drive disabled unless digital output channel
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "gcs_regs.svh"
module gcs_bank #(
  parameter int N = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pads
  input wire logic [N-1:0] pad_in,
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe,
  // converter core
  input wire logic conv_done,
  output logic [1:0] scan_mode,
  output logic scan_active,
  output logic [2:0] conv_channel,
  output logic conv_channel_valid
);
  // ****************************************
  // storage
  // ****************************************
  logic [7:0] pin_cfg_r; // analog or digital per channel
  logic [7:0] dir_cfg_r; // input or output per channel
  logic [7:0] drive_r; // output_drive_type
  logic [7:0] out_lvl_r; // digital_output_level
  logic [7:0] scan_ctl_r; // scan_sequence_control
  logic [7:0] man_sel_r; // manual_channel_select
  logic [7:0] auto_en_r; // auto_scan_channel_enable
  logic [N-1:0] in_level; // synchronised pad levels
  logic ack_r; // answer phase of current access
  logic [31:0] rdata_nxt; // read mux
  logic [5:0] idx; // register index from byte address
  logic wr_go; // write takes effect
  gcs_pin_if #(.N(N)) pins ();
  assign idx = avs_address[7:2];
  assign wr_go = avs_write && ack_r && avs_byteenable[0];
  // one wait cycle per access keeps the read mux off the bus path
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  // ****************************************
  // handshake
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end
  // ****************************************
  // pin configuration registers
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_cfg_r <= `GCS_RST8;
      dir_cfg_r <= `GCS_RST8;
      drive_r <= `GCS_RST8;
      out_lvl_r <= `GCS_RST8;
    end else if (wr_go) begin
      unique case (idx)
        `GCS_IDX_PIN_CFG: pin_cfg_r <= avs_writedata[7:0]; // [RULE10]
        `GCS_IDX_DIR_CFG: dir_cfg_r <= avs_writedata[7:0]; // [RULE11]
        `GCS_IDX_DRIVE: drive_r <= avs_writedata[7:0]; // [RULE1]
        `GCS_IDX_OUT_LVL: out_lvl_r <= avs_writedata[7:0]; // [RULE2]
        default: ; // other indices unmapped or handled elsewhere
      endcase
    end
  end
  // ****************************************
  // scan control registers
  // ****************************************
  // reserved bits masked on write so they always read zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scan_ctl_r <= `GCS_RST8;
      man_sel_r <= `GCS_RST8;
      auto_en_r <= `GCS_RST8;
    end else if (wr_go) begin
      unique case (idx)
        `GCS_IDX_SCAN_CTL: scan_ctl_r <= avs_writedata[7:0] & `GCS_SCAN_CTL_MASK; // [RULE4] [RULE7]
        `GCS_IDX_MAN_SEL: man_sel_r <= avs_writedata[7:0] & `GCS_MAN_SEL_MASK; // [RULE4] [RULE8]
        `GCS_IDX_AUTO_EN: auto_en_r <= avs_writedata[7:0]; // [RULE12]
        default: ; // writes to the input level register are dropped
      endcase
    end
  end
  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rdata_nxt = `GCS_UNMAPPED_DATA;
    unique case (idx)
      `GCS_IDX_PIN_CFG: rdata_nxt = {24'h000000, pin_cfg_r};
      `GCS_IDX_DIR_CFG: rdata_nxt = {24'h000000, dir_cfg_r};
      `GCS_IDX_DRIVE: rdata_nxt = {24'h000000, drive_r};
      `GCS_IDX_OUT_LVL: rdata_nxt = {24'h000000, out_lvl_r};
      `GCS_IDX_IN_LVL: rdata_nxt = {{(32 - N){1'b0}}, in_level}; // [RULE3]
      `GCS_IDX_SCAN_CTL: rdata_nxt = {24'h000000, scan_ctl_r}; // [RULE4]
      `GCS_IDX_MAN_SEL: rdata_nxt = {24'h000000, man_sel_r}; // [RULE4]
      `GCS_IDX_AUTO_EN: rdata_nxt = {24'h000000, auto_en_r};
      default: rdata_nxt = `GCS_UNMAPPED_DATA; // unmapped reads zero
    endcase
  end
  // read data registered in the wait cycle, stands in the answer cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= rdata_nxt;
    end
  end
  // ****************************************
  // pin and scan wiring
  // ****************************************
  assign pins.is_digital = pin_cfg_r[N-1:0];
  assign pins.is_output = dir_cfg_r[N-1:0];
  assign pins.push_pull = drive_r[N-1:0];
  assign pins.level = out_lvl_r[N-1:0];
  assign scan_mode = scan_ctl_r[`GCS_MODE_MSB:`GCS_MODE_LSB]; // [RULE7]
  gcs_pad_ctl #(.N(N)) u_pad (
    .clock(clock),
    .rst_b(rst_b),
    .cfg(pins),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .in_level(in_level)
  );
  // digital channels are withheld from auto scan; manual pick is host duty
  gcs_scan_ctl #(.N(N)) u_scan (
    .clock(clock),
    .rst_b(rst_b),
    .mode(gcs_pkg::gcs_mode_type'(scan_ctl_r[`GCS_MODE_MSB:`GCS_MODE_LSB])),
    .start(scan_ctl_r[`GCS_START_BIT]), // [RULE5] [RULE6]
    .manual_id(man_sel_r[`GCS_CHID_MSB:0]),
    .enables(auto_en_r[N-1:0]),
    .is_digital(pin_cfg_r[N-1:0]),
    .conv_done(conv_done),
    .scan_active(scan_active),
    .chan(conv_channel),
    .chan_valid(conv_channel_valid)
  );
endmodule : gcs_bank

// [tb/gcs_bank_assertions.sv]
// Purpose: port level checks of the pin and scan control bank
// Assumes: one clock domain, reset async active low
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`include "gcs_regs.svh"
module gcs_bank_assertions #(
  parameter int N = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pads
  input wire logic [N-1:0] pad_in,
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  // converter core
  input wire logic conv_done,
  input wire logic [1:0] scan_mode,
  input wire logic scan_active,
  input wire logic [2:0] conv_channel,
  input wire logic conv_channel_valid
);
  // ****************************************
  // bus handshake and register checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // one wait cycle, then the answer
  chk_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait cycle");
  chk_wait_second: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  chk_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("wait while idle");
  chk_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_read_stand: assert property (!$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved without read");
  // mode field follows the written value
  chk_mode_write: assert property (avs_write && !avs_waitrequest && avs_byteenable[0] &&
    avs_address[7:2] == `GCS_IDX_SCAN_CTL |=> scan_mode == $past(avs_writedata[1:0])) else $error("mode not stored");
  // ****************************************
  // scan and pad checks
  // ****************************************
  // one cycle of slack for the registered scan state
  chk_auto_only: assert property (scan_mode != 2'h1 && $past(scan_mode) != 2'h1 |-> !scan_active)
    else $error("scan outside auto mode");
  chk_fly_invalid: assert property (scan_mode[1] && $past(scan_mode[1]) |-> !conv_channel_valid)
    else $error("channel valid in fly mode");
  chk_pad_quiet: assert property ($changed(pad_oe) || $changed(pad_out) |->
    $past(avs_write) || $past(avs_write, 2)) else $error("pad moved without write");
  // channel register trails a done pulse by two edges and the starting write by three
  chk_chan_hold: assert property (scan_active && $past(scan_active) && $changed(conv_channel) |->
    $past(conv_done, 2) || $past(avs_write, 2) || $past(avs_write, 3)) else $error("scan stepped without done");
endmodule : gcs_bank_assertions

// [tb/gcs_bank_tb_top.sv]
// Purpose: self-checking bench of the pin and scan control bank
// Assumes: 10 MHz clock, master waits for waitrequest low however long it takes
// Notes: bench drives every port itself, no partner model
`timescale 1ns/1ps
`include "gcs_regs.svh"
module gcs_bank_tb_top;
  // ****************************************
  // signals and instance
  // ****************************************
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] pad_in = 8'h00;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic conv_done = 1'b0;
  logic [1:0] scan_mode;
  logic scan_active;
  logic [2:0] conv_channel;
  logic conv_channel_valid;
  int err_total = 0;
  int n_compared = 0;
  logic [31:0] rd; // last read word
  gcs_bank #(.N(8)) i_gcs_bank (.clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .conv_done(conv_done), .scan_mode(scan_mode), .scan_active(scan_active),
    .conv_channel(conv_channel), .conv_channel_valid(conv_channel_valid));
  // 100 ns period
  initial begin
    forever #50 clock = ~clock;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // one avalon access; entered just after a rising edge, request held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [5:0] idx, input logic [7:0] d, input logic be0);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= {3'h7, be0};
    avs_read <= !wr;
    avs_write <= wr;
    // right after the edge we still see what the slave sampled; only the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata; // taken at the completing edge
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge so the next call never reassigns in this time step
    @(posedge clock);
  endtask : acc
  // settle registered outputs, then pass the falling edge and return at the next rising edge
  task automatic settle(input int c);
    repeat (c) @(posedge clock);
    @(negedge clock);
    @(posedge clock);
  endtask : settle
  // ****************************************
  // scenarios
  // ****************************************
  logic [5:0] idx_list [8] = '{`GCS_IDX_PIN_CFG, `GCS_IDX_DIR_CFG, `GCS_IDX_DRIVE, `GCS_IDX_OUT_LVL,
    `GCS_IDX_IN_LVL, `GCS_IDX_SCAN_CTL, `GCS_IDX_MAN_SEL, `GCS_IDX_AUTO_EN};
  logic [7:0] rw_mask [8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h13, 8'h0F, 8'hFF};
  task automatic t_reset_and_access();
    foreach (idx_list[i]) begin
      acc(1'b0, idx_list[i], 8'h00, 1'b1);
      cmp("reset value", 32'h0, rd);
    end
    foreach (idx_list[i]) begin
      acc(1'b1, idx_list[i], 8'hFF, 1'b1);
      acc(1'b0, idx_list[i], 8'h00, 1'b1);
      cmp("written ones", {24'h0, rw_mask[i]}, rd);
      acc(1'b1, idx_list[i], 8'h00, 1'b1);
    end
    acc(1'b1, `GCS_IDX_AUTO_EN, 8'h5A, 1'b0);
    acc(1'b0, `GCS_IDX_AUTO_EN, 8'h00, 1'b1);
    cmp("write without byteenable", 32'h0, rd);
    acc(1'b1, 6'h3F, 8'hAA, 1'b1);
    acc(1'b0, 6'h3F, 8'h00, 1'b1);
    cmp("unmapped read", 32'h0, rd);
    $display("test reset_and_access done");
  endtask : t_reset_and_access
  task automatic t_pads();
    acc(1'b1, `GCS_IDX_PIN_CFG, 8'hFF, 1'b1);
    acc(1'b1, `GCS_IDX_DIR_CFG, 8'h0F, 1'b1);
    acc(1'b1, `GCS_IDX_DRIVE, 8'h05, 1'b1);
    acc(1'b1, `GCS_IDX_OUT_LVL, 8'h03, 1'b1);
    pad_in <= 8'hA0;
    settle(3);
    cmp("pad enable", 32'h0D, {24'h0, pad_oe});
    cmp("driven level", 32'h01, {24'h0, pad_out & pad_oe});
    acc(1'b0, `GCS_IDX_IN_LVL, 8'h00, 1'b1);
    cmp("input level", 32'hA0, rd & 32'hF0);
    acc(1'b1, `GCS_IDX_DIR_CFG, 8'h00, 1'b1);
    settle(2);
    cmp("inputs undriven", 32'h0, {24'h0, pad_oe});
    acc(1'b1, `GCS_IDX_DIR_CFG, 8'hFF, 1'b1);
    acc(1'b1, `GCS_IDX_PIN_CFG, 8'h00, 1'b1);
    settle(2);
    cmp("analog undriven", 32'h0, {24'h0, pad_oe});
    $display("test pads done");
  endtask : t_pads
  // reset in mid-run returns registers and pads to zero
  task automatic t_mid_reset();
    acc(1'b1, `GCS_IDX_OUT_LVL, 8'h3C, 1'b1);
    settle(1);
    cmp("level before reset", 32'h3C, {24'h0, pad_out});
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    cmp("pads after reset", 32'h0, {24'h0, pad_out});
    acc(1'b0, `GCS_IDX_OUT_LVL, 8'h00, 1'b1);
    cmp("level after reset", 32'h0, rd);
    $display("test mid_reset done");
  endtask : t_mid_reset
  // one completion pulse from the core
  task automatic done_pulse();
    conv_done <= 1'b1;
    @(posedge clock);
    conv_done <= 1'b0;
    settle(2);
  endtask : done_pulse
  task automatic t_scan();
    logic [2:0] seq [4] = '{3'h2, 3'h3, 3'h5, 3'h2};
    acc(1'b1, `GCS_IDX_AUTO_EN, 8'h2C, 1'b1);
    acc(1'b1, `GCS_IDX_SCAN_CTL, 8'h11, 1'b1);
    settle(3);
    cmp("scan running", 32'h1, {31'h0, scan_active});
    foreach (seq[i]) begin
      cmp("scan channel", {29'h0, seq[i]}, {29'h0, conv_channel});
      done_pulse();
    end
    acc(1'b1, `GCS_IDX_SCAN_CTL, 8'h01, 1'b1);
    settle(3);
    cmp("scan stopped", 32'h0, {31'h0, scan_active});
    // channel 6 is analog here, so the manual pick is a legal one
    acc(1'b1, `GCS_IDX_MAN_SEL, 8'h06, 1'b1);
    acc(1'b1, `GCS_IDX_SCAN_CTL, 8'h10, 1'b1);
    settle(3);
    cmp("start ignored in manual", 32'h0, {31'h0, scan_active});
    cmp("manual channel", 32'h6, {29'h0, conv_channel});
    cmp("manual valid", 32'h1, {31'h0, conv_channel_valid});
    acc(1'b1, `GCS_IDX_MAN_SEL, 8'h09, 1'b1);
    settle(3);
    cmp("reserved id invalid", 32'h0, {31'h0, conv_channel_valid});
    acc(1'b1, `GCS_IDX_SCAN_CTL, 8'h12, 1'b1);
    settle(3);
    cmp("fly mode", 32'h2, {30'h0, scan_mode});
    cmp("fly no scan", 32'h0, {31'h0, scan_active});
    acc(1'b1, `GCS_IDX_SCAN_CTL, 8'h03, 1'b1);
    settle(3);
    cmp("reserved mode", 32'h3, {30'h0, scan_mode});
    cmp("reserved mode no channel", 32'h0, {31'h0, conv_channel_valid});
    $display("test scan done");
  endtask : t_scan
  // ****************************************
  // run control
  // ****************************************
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_reset_and_access();
    t_pads();
    t_scan();
    t_mid_reset();
    finish_test();
  end
  // watchdog, well beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    finish_test();
  end
endmodule : gcs_bank_tb_top
bind gcs_bank gcs_bank_assertions #(.N(N)) i_gcs_bank_assertions (.clock(clock), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .conv_done(conv_done), .scan_mode(scan_mode),
  .scan_active(scan_active), .conv_channel(conv_channel), .conv_channel_valid(conv_channel_valid));
